// [rtl/dual_input_sampler.sv]
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module dual_input_sampler
    import sampler_pkg::*;
#(
    parameter int channels = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [channels-1:0] din,
    input wire logic frame_arrival,
    input wire logic nv_sync_mode,
    input wire logic transition_fail,
    input wire link_status_t [num_ports-1:0] port_link,
    output logic sync_pulse_zero,
    output logic [channels-1:0] sampled
);

    // ************************************************************
    // bus address phase capture
    // ************************************************************
    logic wr_pend_reg;        // write data phase pending
    logic wr_pend_next;
    logic [11:0] addr_reg;    // latched word address
    logic [11:0] addr_next;
    logic [31:0] rdata_reg;   // read data register
    logic [31:0] rdata_next;
    logic take;               // valid address phase
    logic wr_now;             // write data present this cycle

    // configuration and state
    mode_cfg_t cfg_reg;
    mode_cfg_t cfg_next;
    logic strap_done_reg;     // mode strap loaded after reset
    logic strap_done_next;
    logic [31:0] cycle_reg;   // sync cycle time
    logic [31:0] cycle_next;
    slave_state_t cur_reg;    // current state
    slave_state_t cur_next;
    slave_state_t req_reg;    // requested state
    slave_state_t req_next;
    logic err_reg;            // error flag
    logic err_next;
    logic pend_reg;           // transition in progress
    logic pend_next;
    logic [63:0] latch_reg;   // next sample time reported
    logic [63:0] latch_next;

    // timer links
    logic [63:0] dc_time;
    logic [63:0] target;
    logic load_lo;
    logic load_hi;
    logic capture;

    assign take = hsel && hready && htrans[1];
    assign wr_now = wr_pend_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;

    // timer target writes only accepted in sync mode
    // no configuration
    assign load_lo = wr_now && cfg_reg.sync_mode && addr_reg == target_lo_off;
    assign load_hi = wr_now && cfg_reg.sync_mode && addr_reg == target_hi_off;

    // ************************************************************
    // register next state
    // ************************************************************
    always_comb begin
        wr_pend_next = take && hwrite;
        addr_next = take ? {haddr[11:2], 2'b00} : addr_reg;
        rdata_next = rdata_reg;
        cfg_next = cfg_reg;
        strap_done_next = 1'b1;
        cycle_next = cycle_reg;
        cur_next = cur_reg;
        req_next = req_reg;
        err_next = err_reg;
        pend_next = pend_reg;
        latch_next = latch_reg;
        if (!strap_done_reg) begin
            cfg_next.sync_mode = nv_sync_mode;
            cfg_next.dc_en = nv_sync_mode;
            cfg_next.fmt64 = nv_sync_mode;
            cfg_next.fmt32 = 1'b0;
        end
        // writes: mode and cycle only in sync mode
        if (wr_now && cfg_reg.sync_mode) begin
            if (addr_reg == mode_off) begin
                cfg_next.dc_en = hwdata[dc_en_bit];
                if (!(hwdata[fmt32_bit] && hwdata[fmt64_bit])) begin
                    if (!hwdata[fmt32_bit] || !cfg_reg.fmt64) begin
                        cfg_next.fmt32 = hwdata[fmt32_bit];
                    end
                    if (!hwdata[fmt64_bit] || !cfg_reg.fmt32) begin
                        cfg_next.fmt64 = hwdata[fmt64_bit];
                    end
                end
            end
            if (addr_reg == sync_cfg_off) begin
                cycle_next = hwdata;
            end
        end
        // state request and error clear
        if (wr_now && addr_reg == state_ctl_off) begin
            if (hwdata[err_clr_bit]) begin
                err_next = 1'b0;
            end
            if (hwdata[3:0] != 4'h0) begin
                req_next = slave_state_t'(hwdata[3:0]);
                pend_next = 1'b1;
            end
        end
        if (pend_reg) begin
            pend_next = 1'b0;
            if (transition_fail) begin
                err_next = 1'b1;
            end else begin
                cur_next = req_reg;
            end
        end
        if (capture && cfg_reg.sync_mode) begin
            latch_next = target;
        end
        // read mux
        if (take && !hwrite) begin
            unique case ({haddr[11:2], 2'b00})
                mode_off: rdata_next = {28'h000_0000, cfg_reg.dc_en, cfg_reg.fmt64,
                                        cfg_reg.fmt32, cfg_reg.sync_mode};
                sync_cfg_off: rdata_next = cycle_reg;
                target_lo_off: rdata_next = target[31:0];
                target_hi_off: rdata_next = target[63:32];
                inputs_off: rdata_next = {{(32-channels){1'b0}}, sampled};
                time_lo_off: rdata_next = (cfg_reg.fmt32 || cfg_reg.fmt64) ? latch_reg[31:0] : zero_word;
                time_hi_off: rdata_next = cfg_reg.fmt64 ? latch_reg[63:32] : zero_word;
                state_sts_off: rdata_next = {20'h0_0000, req_reg, 3'b000, err_reg, cur_reg};
                link_off: rdata_next = {28'h000_0000, port_link};
                dc_time_lo_off: rdata_next = cfg_reg.dc_en ? dc_time[31:0] : zero_word;
                dc_time_hi_off: rdata_next = cfg_reg.dc_en ? dc_time[63:32] : zero_word;
                default: rdata_next = zero_word;
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= '0;
            rdata_reg <= '0;
            cfg_reg <= '0;
            strap_done_reg <= 1'b0;
            cycle_reg <= sync_cycle_rst;
            cur_reg <= st_init;
            req_reg <= st_init;
            err_reg <= 1'b0;
            pend_reg <= 1'b0;
            latch_reg <= '0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            addr_reg <= addr_next;
            rdata_reg <= rdata_next;
            cfg_reg <= cfg_next;
            strap_done_reg <= strap_done_next;
            cycle_reg <= cycle_next;
            cur_reg <= cur_next;
            req_reg <= req_next;
            err_reg <= err_next;
            pend_reg <= pend_next;
            latch_reg <= latch_next;
        end
    end

    // ************************************************************
    // sampling trigger select
    // ************************************************************
    // frame trigger, or sync pulse in sync mode
    assign capture = cfg_reg.sync_mode ? sync_pulse_zero : frame_arrival;

    sync_timer u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(cfg_reg.sync_mode && cfg_reg.dc_en),
        .cycle_ns(cycle_reg),
        .load_lo(load_lo),
        .load_hi(load_hi),
        .load_data(hwdata),
        .dc_time(dc_time),
        .target(target),
        .sync_pulse_zero(sync_pulse_zero)
    );

    input_capture #(.width(channels)) u_cap (
        .hclk(hclk),
        .hresetn(hresetn),
        .pins(din),
        .capture(capture),
        .levels(sampled)
    );

    // ************************************************************
    // checks
    // ************************************************************
    // never both
    time_form_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(cfg_reg.fmt32 && cfg_reg.fmt64)) else $error("both time forms on");
    frame_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (strap_done_reg && !cfg_reg.sync_mode) |-> !cfg_reg.dc_en && !sync_pulse_zero)
        else $error("clock active in frame mode");
    fail_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pend_reg && transition_fail) |=> err_reg && cur_reg == $past(cur_reg))
        else $error("failed transition changed state");
    latch_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (capture && cfg_reg.sync_mode) |=> latch_reg == $past(target))
        else $error("next time not updated on sample");
    frame_cap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!cfg_reg.sync_mode && strap_done_reg) |-> capture == frame_arrival)
        else $error("frame trigger not used");
    err_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_now && addr_reg == state_ctl_off && hwdata[err_clr_bit] && !pend_reg) |=> !err_reg)
        else $error("error not cleared");

endmodule : dual_input_sampler

// [rtl/input_capture.sv]
`timescale 1ns/10ps
module input_capture
    import sampler_pkg::*;
#(
    parameter int width = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [width-1:0] pins,
    input wire logic capture,
    output logic [width-1:0] levels
);

    // ************************************************************
    // two-stage synchroniser and common capture
    // ************************************************************
    logic [width-1:0] meta_reg;   // first stage, read only by second
    logic [width-1:0] sync_reg;   // second stage
    logic [width-1:0] cap_reg;    // captured levels
    logic [width-1:0] cap_next;

    // next captured value: only the level at the instant counts
    always_comb begin
        cap_next = cap_reg;
        if (capture) begin
            cap_next = sync_reg;
        end
    end

    // registers; one capture strobe for all channels
    // two-stage synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
            cap_reg <= '0;
        end else begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
            cap_reg <= cap_next;
        end
    end

    assign levels = cap_reg;

    capture_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
        capture |=> (levels == $past(sync_reg))) else $error("capture missed");
    capture_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !capture |=> $stable(levels)) else $error("levels changed without capture");

endmodule : input_capture

// [rtl/sampler_pkg.sv]
package sampler_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [11:0] mode_off = 12'h000;        // mode and time format control
    localparam logic [11:0] sync_cfg_off = 12'h004;    // sync cycle time in ns
    localparam logic [11:0] target_lo_off = 12'h008;   // next sync target, low word
    localparam logic [11:0] target_hi_off = 12'h00C;   // next sync target, high word
    localparam logic [11:0] inputs_off = 12'h010;      // captured input levels
    localparam logic [11:0] time_lo_off = 12'h014;     // next sample time, low word
    localparam logic [11:0] time_hi_off = 12'h018;     // next sample time, high word
    localparam logic [11:0] state_ctl_off = 12'h01C;   // state request and error clear
    localparam logic [11:0] state_sts_off = 12'h020;   // current and requested state
    localparam logic [11:0] link_off = 12'h024;        // per-port link status
    localparam logic [11:0] dc_time_lo_off = 12'h028;  // local clock time, low word
    localparam logic [11:0] dc_time_hi_off = 12'h02C;  // local clock time, high word

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int mode_sync_bit = 0;       // 1 = clock-synchronous mode
    localparam int fmt32_bit = 1;           // 1 = 32-bit next time form
    localparam int fmt64_bit = 2;           // 1 = 64-bit next time form
    localparam int dc_en_bit = 3;           // clock cyclic enable
    localparam int err_clr_bit = 8;         // write 1 clears the error flag
    localparam int err_bit = 4;             // error flag in status
    localparam logic [31:0] sync_cycle_rst = 32'h000F_4240; // 1 ms in ns
    localparam logic [31:0] zero_word = 32'h0000_0000;
    localparam logic [63:0] ns_per_clk = 64'h0000_0000_0000_0019; // 25 ns clock
    localparam int num_ports = 2;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [3:0] {
        st_init = 4'h1,
        st_preop = 4'h2,
        st_boot = 4'h3,
        st_safeop = 4'h4,
        st_op = 4'h8
    } slave_state_t;

    typedef struct packed {
        logic carrier;   // carrier present
        logic open;      // port open
    } link_status_t;

    typedef struct packed {
        logic sync_mode; // clock-synchronous when set
        logic fmt32;     // 32-bit time form selected
        logic fmt64;     // 64-bit time form selected
        logic dc_en;     // local clock enabled
    } mode_cfg_t;

endpackage : sampler_pkg

// [rtl/sync_timer.sv]
`timescale 1ns/10ps
module sync_timer
    import sampler_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic [31:0] cycle_ns,
    input wire logic load_lo,
    input wire logic load_hi,
    input wire logic [31:0] load_data,
    output logic [63:0] dc_time,
    output logic [63:0] target,
    output logic sync_pulse_zero
);

    // ************************************************************
    // local clock, sync target and pulse
    // ************************************************************
    logic [63:0] time_reg;    // local clock time in ns
    logic [63:0] time_next;
    logic [63:0] target_reg;  // programmed sync target
    logic [63:0] target_next;
    logic pulse_reg;          // one-cycle sync pulse
    logic pulse_next;
    logic hit;                // clock reached target

    // next values of clock, target and pulse
    always_comb begin
        time_next = time_reg + ns_per_clk;
        target_next = target_reg;
        hit = run && (time_reg >= target_reg);
        pulse_next = 1'b0;
        if (hit) begin
            pulse_next = 1'b1;
            target_next = target_reg + {32'h0000_0000, cycle_ns};
        end
        // software writes win over advancing
        if (load_lo) begin
            target_next[31:0] = load_data;
        end
        if (load_hi) begin
            target_next[63:32] = load_data;
        end
    end

    // registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            time_reg <= '0;
            target_reg <= '0;
            pulse_reg <= 1'b0;
        end else begin
            time_reg <= time_next;
            target_reg <= target_next;
            pulse_reg <= pulse_next;
        end
    end

    assign dc_time = time_reg;
    assign target = target_reg;
    assign sync_pulse_zero = pulse_reg;

    sync_fire_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hit && !load_lo && !load_hi) |=> (sync_pulse_zero && target == $past(target) + $past(cycle_ns)))
        else $error("sync pulse or target step wrong");
    sync_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !run |=> !sync_pulse_zero) else $error("pulse while stopped");

endmodule : sync_timer

// [tb/dual_input_sampler_tb_top.sv]
`timescale 1ns/10ps
module dual_input_sampler_tb_top
    import sampler_pkg::*;
;
    // ************************************************************
    // signals
    // ************************************************************
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp; // bus control
    logic frame_req, frame_arrival, nv_sync_mode, transition_fail, sync_pulse_zero;
    logic [31:0] haddr, hwdata, hrdata, t0, cyc; // bus data and model times
    logic [1:0] htrans, din, sampled, v; // pins and levels
    logic [2:0] hsize;
    logic [3:0] link_cfg;
    logic [3:0] sts [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8}; // every state code
    link_status_t [num_ports-1:0] port_link;
    logic [1:0] samp_q [$]; // model: levels expected at each trigger
    int n_errors = 0, checks = 0, seed = 26851, npulse = 0, n;

    dual_input_sampler u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .din(din), .frame_arrival(frame_arrival),
        .nv_sync_mode(nv_sync_mode), .transition_fail(transition_fail), .port_link(port_link),
        .sync_pulse_zero(sync_pulse_zero), .sampled(sampled));
    fieldbus_master_model u_master (.hclk(hclk), .hresetn(hresetn), .frame_req(frame_req),
        .link_cfg(link_cfg), .frame_arrival(frame_arrival), .port_link(port_link));

    // clock and pulse monitor
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (sync_pulse_zero === 1'b1) npulse <= npulse + 1;
    end
    // hang guard
    initial begin
        #2_000_000;
        n_errors++;
        final_report();
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic final_report();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic cycles(input int k);
        repeat (k) @(posedge hclk);
    endtask : cycles
    // waits for hready high at a rising edge, bounded
    task automatic wait_rdy();
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            k++;
            if (k > 50) begin
                n_errors++;
                final_report();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy
    // one single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {20'h0_0000, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr
    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        check(what, exp, x);
    endtask : rdchk
    task automatic do_reset(input logic m);
        @(posedge hclk);
        hresetn <= 1'b0;
        nv_sync_mode <= m;
        cycles(2);
        hresetn <= 1'b1;
        cycles(2);
    endtask : do_reset
    // bounded wait for a sync pulse, returns edges waited
    task automatic wait_pulse(output int k);
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (sync_pulse_zero !== 1'b1 && k < 200);
        if (k >= 200) begin
            n_errors++;
            final_report();
        end
    endtask : wait_pulse

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'b00;
        hsize = 3'b010;
        din = 2'b00;
        frame_req = 1'b0;
        nv_sync_mode = 1'b0;
        transition_fail = 1'b0;
        link_cfg = 4'h0;
        do_reset(1'b0);
        rdchk("mode", mode_off, zero_word);
        wr(sync_cfg_off, 32'h0000_03E8);
        wr(mode_off, 32'h0000_000D);
        rdchk("cycle", sync_cfg_off, sync_cycle_rst);
        rdchk("mode", mode_off, zero_word);
        rdchk("clock", dc_time_lo_off, zero_word);
        wr(12'h040, 32'hFFFF_FFFF);
        rdchk("unmapped", 12'h040, zero_word);
        for (int i = 0; i < 16; i++) begin
            link_cfg <= 4'(i);
            cycles(2);
            rdchk("link", link_off, 32'(i));
        end
        for (int i = 0; i < 6; i++) begin
            v = 2'($random(seed));
            din <= v;
            samp_q.push_back(v);
            cycles(4);
            frame_req <= 1'b1;
            cycles(1);
            frame_req <= 1'b0;
            cycles(2);
            din <= ~v;
            cycles(2);
            check("sampled", 32'(samp_q[0]), 32'(sampled));
            rdchk("inputs", inputs_off, 32'(samp_q.pop_front()));
        end
        check("pulses", zero_word, 32'(npulse));
        for (int i = 0; i < 5; i++) begin
            wr(state_ctl_off, 32'(sts[i]));
            cycles(2);
            rdchk("state", state_sts_off, {20'h0_0000, sts[i], 4'h0, sts[i]});
        end
        transition_fail <= 1'b1;
        wr(state_ctl_off, 32'h0000_0002);
        cycles(2);
        transition_fail <= 1'b0;
        rdchk("state", state_sts_off, 32'h0000_0218);
        wr(state_ctl_off, 32'h0000_0108);
        cycles(2);
        rdchk("state", state_sts_off, 32'h0000_0808);
        do_reset(1'b1);
        rdchk("mode", mode_off, 32'h0000_000D);
        cyc = 32'h0000_03E8;
        wr(sync_cfg_off, cyc);
        wr(target_hi_off, zero_word);
        bus(1'b0, dc_time_lo_off, zero_word, t0);
        t0 = t0 + 32'h0000_01F4;
        wr(target_lo_off, t0);
        v = 2'($random(seed));
        din <= v;
        samp_q.push_back(v);
        wait_pulse(n);
        cycles(2);
        check("sampled", 32'(samp_q[0]), 32'(sampled));
        rdchk("next lo", time_lo_off, t0 + cyc);
        rdchk("next hi", time_hi_off, zero_word);
        rdchk("inputs", inputs_off, 32'(samp_q.pop_front()));
        v = 2'($random(seed));
        samp_q.push_back(v);
        din <= ~v;
        cycles(2);
        din <= v;
        wait_pulse(n);
        cycles(2);
        check("sampled", 32'(samp_q.pop_front()), 32'(sampled));
        rdchk("next lo", time_lo_off, t0 + cyc + cyc);
        wait_pulse(n);
        wait_pulse(n);
        check("period", cyc / 32'h0000_0019, 32'(n));
        wr(mode_off, 32'h0000_000F);
        rdchk("mode", mode_off, 32'h0000_000D);
        wr(mode_off, 32'h0000_0009);
        rdchk("next lo", time_lo_off, zero_word);
        wr(mode_off, 32'h0000_000B);
        rdchk("mode", mode_off, 32'h0000_000B);
        rdchk("next hi", time_hi_off, zero_word);
        final_report();
    end
endmodule : dual_input_sampler_tb_top

// [tb/fieldbus_master_model.sv]
`timescale 1ns/10ps
module fieldbus_master_model
    import sampler_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic frame_req,
    input wire logic [3:0] link_cfg,
    output logic frame_arrival,
    output link_status_t [num_ports-1:0] port_link
);
    // ************************************************************
    // frame source
    // ************************************************************
    // dc capable master
    // a frame reaches the slave one cycle after the bench asks for it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_arrival <= 1'b0;
        end else begin
            frame_arrival <= frame_req;
        end
    end
    // port status as the bench sets it
    assign port_link = link_cfg;
endmodule : fieldbus_master_model
